// ===== can_cfg_map.svh
`ifndef CAN_CFG_MAP_SVH
`define CAN_CFG_MAP_SVH

// Byte addresses of the configuration registers
`define ADDR_MODE 12'h000
`define ADDR_IRQ_ENABLE 12'h004
`define ADDR_BIT_TIMING_ZERO 12'h008
`define ADDR_BIT_TIMING_ONE 12'h00C
`define ADDR_WARN_LIMIT 12'h010
`define ADDR_OUTPUT_CTRL 12'h014
`define ADDR_CLOCK_DIV 12'h018
`define ADDR_ACC_CODE 12'h01C
`define ADDR_ACC_MASK 12'h020
`define ADDR_STATUS 12'h024
`define ADDR_ERR_COUNTS 12'h028
`define ADDR_EVENT_STATUS 12'h02C

// Field positions
`define MODE_RESET_BIT 0
`define MODE_FILTER_BIT 3
`define STATUS_ERR_BIT 6
`define STATUS_CFG_BIT 0
`define CLKDIV_EN_BIT 3

// Reset values
`define WARN_LIMIT_RST 8'h60
`define CLKDIV_RST 8'h08
`define IRQ_ENABLE_RST 8'h00
`define MODE_RST 8'h01

// Timing limits in quanta
`define SYNC_TQ 1
`define SJW_MAX_TQ 4

`endif

// ===== can_cfg_pkg.sv
package can_cfg_pkg;
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_BEFORE = 2'b01,
    SEG_AFTER = 2'b10
  } seg_e;
endpackage : can_cfg_pkg

// ===== can_controller_config.sv
`include "can_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module can_controller_config #(
  parameter int QUANTUM_MIN = 2,
  parameter int QUANTUM_MAX = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic tx_bit,
  input wire logic [7:0] tx_err_count,
  input wire logic [7:0] rx_err_count,
  input wire logic [7:0] irq_events,
  input wire logic id_valid,
  input wire logic id_extended,
  input wire logic [28:0] id_value,
  output logic id_accept,
  output logic [7:0] irq_pending,
  output logic config_state,
  output logic sample_pulse,
  output logic sampled_bit,
  output logic tx_pin_primary,
  output logic tx_pin_secondary,
  output logic divided_clock_pin
);

  logic [7:0] mode_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] bit_timing_reg_zero;
  logic [7:0] bit_timing_reg_one;
  logic [7:0] error_warning_limit;
  logic clock_mode_reg;
  logic [7:0] clock_div_reg;
  logic [31:0] acceptance_code_bytes;
  logic [31:0] acceptance_mask_bytes;
  logic error_status_flag;
  logic [7:0] event_reg;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic cfg_open;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign cfg_open = mode_reg[`MODE_RESET_BIT];

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `ADDR_EVENT_STATUS) && (a[1:0] == 2'b00);
  endfunction : mapped

  assign addr_ok = mapped(paddr);

  // Slave answers in the first access cycle; no wait states.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !addr_ok;
  end

  // Mode register: hardware reset enters configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= `MODE_RST;
    else if (wr_en && paddr == `ADDR_MODE)
      mode_reg <= {4'h0, pwdata[3:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_state <= 1'b1;
    else
      config_state <= (wr_en && paddr == `ADDR_MODE) ? pwdata[`MODE_RESET_BIT] : cfg_open;
  end

  // Enables survive software reset, since only the hardware reset touches them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable_reg <= `IRQ_ENABLE_RST;
    else if (wr_en && paddr == `ADDR_IRQ_ENABLE)
      irq_enable_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_timing_reg_zero <= 8'h00;
      bit_timing_reg_one <= 8'h00;
    end
    else if (wr_en && cfg_open)
    begin
      if (paddr == `ADDR_BIT_TIMING_ZERO)
        bit_timing_reg_zero <= pwdata[7:0];
      if (paddr == `ADDR_BIT_TIMING_ONE)
        bit_timing_reg_one <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      error_warning_limit <= `WARN_LIMIT_RST;
    else if (wr_en && cfg_open && paddr == `ADDR_WARN_LIMIT)
      error_warning_limit <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_mode_reg <= 1'b0;
    else if (wr_en && cfg_open && paddr == `ADDR_OUTPUT_CTRL)
      clock_mode_reg <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_div_reg <= `CLKDIV_RST;
    else if (wr_en && paddr == `ADDR_CLOCK_DIV)
      clock_div_reg <= {4'h0, pwdata[3:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acceptance_code_bytes <= 32'h0000_0000;
      acceptance_mask_bytes <= 32'h0000_0000;
    end
    else if (wr_en && cfg_open)
    begin
      if (paddr == `ADDR_ACC_CODE)
        acceptance_code_bytes <= pwdata;
      if (paddr == `ADDR_ACC_MASK)
        acceptance_mask_bytes <= pwdata;
    end
  end

  // Error warning: limit passed by either counter
  logic warn_now;
  assign warn_now = (tx_err_count > error_warning_limit) || (rx_err_count > error_warning_limit);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      error_status_flag <= 1'b0;
    else
      error_status_flag <= warn_now;
  end

  // Sticky event bits, set wins over a write-one clear
  logic [7:0] ev_in;
  assign ev_in = {irq_events[7:3], irq_events[2] | (warn_now & ~error_status_flag),
    irq_events[1:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_reg <= 8'h00;
    else if (wr_en && paddr == `ADDR_EVENT_STATUS)
      event_reg <= (event_reg & ~pwdata[7:0]) | ev_in;
    else
      event_reg <= event_reg | ev_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_pending <= 8'h00;
    else
      irq_pending <= event_reg & irq_enable_reg;
  end

  // Read mux
  logic [31:0] rd_next;
  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (paddr)
      `ADDR_MODE: rd_next = {24'h0, mode_reg};
      `ADDR_IRQ_ENABLE: rd_next = {24'h0, irq_enable_reg};
      `ADDR_BIT_TIMING_ZERO: rd_next = {24'h0, bit_timing_reg_zero};
      `ADDR_BIT_TIMING_ONE: rd_next = {24'h0, bit_timing_reg_one};
      `ADDR_WARN_LIMIT: rd_next = {24'h0, error_warning_limit};
      `ADDR_OUTPUT_CTRL: rd_next = {31'h0, clock_mode_reg};
      `ADDR_CLOCK_DIV: rd_next = {24'h0, clock_div_reg};
      `ADDR_ACC_CODE: rd_next = acceptance_code_bytes;
      `ADDR_ACC_MASK: rd_next = acceptance_mask_bytes;
      `ADDR_STATUS: rd_next = {24'h0, 1'b0, error_status_flag, 5'h0, cfg_open};
      `ADDR_ERR_COUNTS: rd_next = {16'h0, rx_err_count, tx_err_count};
      `ADDR_EVENT_STATUS: rd_next = {24'h0, event_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= rd_next;
  end

  // Acceptance filter
  function automatic logic match(input logic [31:0] id, input logic [31:0] code,
                                 input logic [31:0] mask);
    match = &(~(id ^ code) | mask);
  endfunction : match

  logic [31:0] id_aligned;
  logic single_hit;
  logic dual_hit;
  logic [31:0] id_unused;
  assign id_aligned = id_extended ? {id_value, 3'b000} : {id_value[10:0], 21'h0};
  // Bits below the identifier never block a match in single-filter form
  assign id_unused = id_extended ? 32'h0000_0007 : 32'h001f_ffff;
  assign single_hit = match(id_aligned, acceptance_code_bytes,
    acceptance_mask_bytes | id_unused);
  // Two filters: upper and lower half-words each cover the identifier head
  assign dual_hit = match({id_aligned[31:16], 16'h0}, {acceptance_code_bytes[31:16], 16'h0},
    {acceptance_mask_bytes[31:16], 16'h0}) ||
    match({id_aligned[31:16], 16'h0}, {acceptance_code_bytes[15:0], 16'h0},
    {acceptance_mask_bytes[15:0], 16'h0});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      id_accept <= 1'b0;
    else
      id_accept <= id_valid && (mode_reg[`MODE_FILTER_BIT] ? single_hit : dual_hit);
  end

  // Quantum prescaler: quantum = 2*(brp+1) input clocks, 2..128
  logic [6:0] tq_cnt;
  logic tq_tick;
  logic [6:0] tq_len;
  assign tq_len = {bit_timing_reg_zero[5:0], 1'b1};
  assign tq_tick = (tq_cnt == tq_len) && !cfg_open;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tq_cnt <= 7'h00;
    else if (cfg_open || tq_tick)
      tq_cnt <= 7'h00;
    else
      tq_cnt <= tq_cnt + 7'h01;
  end

  // Receive pin synchroniser
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  logic rx_edge;
  assign rx_edge = rx_prev && !rx_sync;

  logic [4:0] seg1;
  logic [4:0] seg2;
  logic [2:0] sjw;
  assign seg1 = {1'b0, bit_timing_reg_one[3:0]} + 5'd1;
  assign seg2 = {2'b00, bit_timing_reg_one[6:4]} + 5'd1;
  assign sjw = {1'b0, bit_timing_reg_zero[7:6]} + 3'd1;

  can_cfg_pkg::seg_e seg_reg;
  logic [4:0] q_cnt;
  logic [5:0] seg1_eff;
  logic [4:0] seg2_eff;
  logic edge_seen;
  logic [2:0] smp_hist;

  // Bit timing machine with resynchronisation by at most the jump width
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seg_reg <= can_cfg_pkg::SEG_SYNC;
      q_cnt <= 5'd0;
      seg1_eff <= 6'd1;
      seg2_eff <= 5'd1;
      edge_seen <= 1'b0;
    end
    else if (cfg_open)
    begin
      seg_reg <= can_cfg_pkg::SEG_SYNC;
      q_cnt <= 5'd0;
      seg1_eff <= {1'b0, seg1};
      seg2_eff <= seg2;
      edge_seen <= 1'b0;
    end
    else if (tq_tick)
    begin
      unique case (seg_reg)
        can_cfg_pkg::SEG_SYNC:
        begin
          seg_reg <= can_cfg_pkg::SEG_BEFORE;
          q_cnt <= 5'd1;
          seg1_eff <= {1'b0, seg1};
          seg2_eff <= seg2;
          edge_seen <= rx_edge;
        end
        can_cfg_pkg::SEG_BEFORE:
        begin
          if (rx_edge && !edge_seen)
          begin
            edge_seen <= 1'b1;
            seg1_eff <= {1'b0, seg1} + {3'b000, (q_cnt < {2'b00, sjw}) ? q_cnt[2:0] : sjw};
          end
          if ({1'b0, q_cnt} >= seg1_eff)
          begin
            seg_reg <= can_cfg_pkg::SEG_AFTER;
            q_cnt <= 5'd1;
          end
          else
            q_cnt <= q_cnt + 5'd1;
        end
        can_cfg_pkg::SEG_AFTER:
        begin
          if (rx_edge && !edge_seen)
          begin
            edge_seen <= 1'b1;
            seg2_eff <= (seg2 > {2'b00, sjw}) ? seg2 - {2'b00, sjw} : q_cnt;
          end
          if (q_cnt >= seg2_eff)
            seg_reg <= can_cfg_pkg::SEG_SYNC;
          else
            q_cnt <= q_cnt + 5'd1;
        end
        default: seg_reg <= can_cfg_pkg::SEG_SYNC;
      endcase
    end
  end

  logic at_sample;
  assign at_sample = tq_tick && seg_reg == can_cfg_pkg::SEG_BEFORE && {1'b0, q_cnt} >= seg1_eff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      smp_hist <= 3'b111;
    else if (tq_tick)
      smp_hist <= {smp_hist[1:0], rx_sync};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_pulse <= 1'b0;
      sampled_bit <= 1'b1;
    end
    else
    begin
      sample_pulse <= at_sample;
      if (at_sample)
        sampled_bit <= bit_timing_reg_one[7] ?
          ((smp_hist[0] & smp_hist[1]) | (smp_hist[1] & rx_sync) | (smp_hist[0] & rx_sync)) :
          rx_sync;
    end
  end

  // Transmit pins; bit clock high through the sync segment and the segment before the sample point, low for the segment after
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_pin_primary <= 1'b1;
      tx_pin_secondary <= 1'b0;
    end
    else
    begin
      tx_pin_primary <= cfg_open ? 1'b1 : tx_bit;
      if (clock_mode_reg)
        tx_pin_secondary <= !cfg_open && (seg_reg != can_cfg_pkg::SEG_AFTER);
      else
        tx_pin_secondary <= cfg_open ? 1'b0 : !tx_bit;
    end
  end

  // Divided clock: toggle every n+1 input clocks gives divide by 2(n+1)
  logic [2:0] div_cnt;
  logic [2:0] div_top;
  // Code 7 would divide by 16, past the top divisor of 14, so it repeats code 6
  assign div_top = (clock_div_reg[2:0] == 3'd7) ? 3'd6 : clock_div_reg[2:0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 3'd0;
      divided_clock_pin <= 1'b0;
    end
    else if (!clock_div_reg[`CLKDIV_EN_BIT])
    begin
      div_cnt <= 3'd0;
      divided_clock_pin <= 1'b0;
    end
    else if (div_cnt >= div_top)
    begin
      div_cnt <= 3'd0;
      divided_clock_pin <= !divided_clock_pin;
    end
    else
      div_cnt <= div_cnt + 3'd1;
  end

  AST_HW_RESET_CFG: assert property (@(posedge pclk) $rose(presetn) |-> config_state)
    else $error("not in config after reset");
  AST_SW_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `ADDR_MODE && pwdata[0] |=> config_state)
    else $error("sw reset missed");
  AST_LEAVE_CFG: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `ADDR_MODE && !pwdata[0] |=> !config_state)
    else $error("config not left");
  AST_TIMING_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_open |=> $stable(bit_timing_reg_zero) && $stable(bit_timing_reg_one))
    else $error("timing changed outside config");
  AST_FILTER_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_open |=> $stable(acceptance_code_bytes) && $stable(acceptance_mask_bytes))
    else $error("filter changed outside config");
  AST_MODE_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_open |=> $stable(clock_mode_reg) && $stable(error_warning_limit))
    else $error("output mode changed outside config");
  AST_WARN: assert property (@(posedge pclk) disable iff (!presetn)
    tx_err_count > error_warning_limit |=> error_status_flag)
    else $error("warning flag missing");
  AST_NORMAL_TX: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_mode_reg && !cfg_open ##1 !cfg_open |-> tx_pin_secondary == !tx_pin_primary)
    else $error("secondary not inverse");
  AST_DIV_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_div_reg[3] |=> !divided_clock_pin)
    else $error("clock pin not stopped");
  AST_DIV_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && clock_div_reg[3:0] == 4'h8 ##1 clock_div_reg[3:0] == 4'h8
    |-> $changed(divided_clock_pin))
    else $error("divide by two wrong");
  AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    irq_enable_reg == 8'h00 |=> irq_pending == 8'h00)
    else $error("disabled interrupt pending");

  COV_SW_RESET: cover property (@(posedge pclk) disable iff (!presetn)
    !config_state ##1 config_state);
  COV_ACCEPT: cover property (@(posedge pclk) disable iff (!presetn) id_accept);
  COV_SAMPLE: cover property (@(posedge pclk) disable iff (!presetn) sample_pulse);
  COV_CLOCK_MODE: cover property (@(posedge pclk) disable iff (!presetn)
    clock_mode_reg && !cfg_open);

endmodule : can_controller_config
`default_nettype wire

// ===== can_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [15:0] bit_clocks,
  input wire logic tx_pin_primary,
  output logic node_bit,
  output logic rx_pin
);
  logic [15:0] cnt_reg;
  logic [7:0] pat_reg;
  // Dominant zero wins, so the bus is the AND of both drivers
  assign rx_pin = tx_pin_primary & node_bit;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 16'h0000;
      pat_reg <= 8'h5b;
      node_bit <= 1'b1;
    end
    else if (!run)
    begin
      // Idle bus floats back to recessive through its termination
      cnt_reg <= 16'h0000;
      node_bit <= 1'b1;
    end
    else if (cnt_reg == bit_clocks - 16'h0001)
    begin
      // Same bit period as the device, so edges stay in its sync segment
      cnt_reg <= 16'h0000;
      node_bit <= pat_reg[0];
      pat_reg <= {pat_reg[0], pat_reg[7:1]};
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule : can_bus_node
`default_nettype wire

// ===== can_controller_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_cfg_map.svh"
module can_controller_config_tb;
  logic pclk, presetn, psel, penable, pwrite, tx_bit, id_valid, id_extended, run, msel, e;
  logic pready, pslverr, id_accept, config_state, sample_pulse, sampled_bit, rx_pin, node_bit;
  logic tx_pin_primary, tx_pin_secondary, divided_clock_pin, msig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, q;
  logic [7:0] tx_err_count, rx_err_count, irq_events, irq_pending;
  logic [28:0] id_value;
  logic [15:0] bit_clocks;
  logic [11:0] ra [8];
  logic [31:0] rv [8];
  int n_fail, n_checks;
  assign msig = msel ? divided_clock_pin : tx_pin_secondary;

  can_controller_config can_controller_config_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_pin, .tx_bit, .tx_err_count, .rx_err_count,
    .irq_events, .id_valid, .id_extended, .id_value, .id_accept, .irq_pending, .config_state,
    .sample_pulse, .sampled_bit, .tx_pin_primary, .tx_pin_secondary, .divided_clock_pin);
  can_bus_node can_bus_node_inst (.pclk, .presetn, .run, .bit_clocks, .tx_pin_primary,
    .node_bit, .rx_pin);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (t >= 20)
      n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q & m, x);
  endtask : rdc

  function automatic logic fexp(input logic x, input logic [28:0] id, input logic s,
                                input logic [31:0] c, input logic [31:0] m);
    logic [31:0] w;
    w = x ? {id, 3'b000} : {id[10:0], 21'h00_0000};
    if (s)
      return ((w ^ c) & ~m & (x ? 32'hffff_fff8 : 32'hffe0_0000)) == 32'h0000_0000;
    return (((w[31:16] ^ c[31:16]) & ~m[31:16]) == 16'h0000)
      || (((w[31:16] ^ c[15:0]) & ~m[15:0]) == 16'h0000);
  endfunction : fexp

  function automatic int bitlen(input logic [31:0] t0, input logic [31:0] t1, input logic hi);
    return 2 * (t0[5:0] + 1) * (2 + t1[3:0] + (hi ? 0 : t1[6:4] + 1));
  endfunction : bitlen

  task automatic fid(input logic x, input logic [28:0] id, input logic s,
                     input logic [31:0] c, input logic [31:0] m);
    @(posedge pclk);
    id_valid <= 1'b1;
    id_extended <= x;
    id_value <= id;
    @(posedge pclk);
    id_valid <= 1'b0;
    @(posedge pclk);
    chk("accept", id_accept, fexp(x, id, s, c, m));
  endtask : fid

  task automatic frand(input logic s);
    logic [31:0] c, m, w;
    logic x;
    c = rnd();
    m = rnd() & rnd();
    wr(`ADDR_MODE, 32'h0000_0001);
    wr(`ADDR_ACC_CODE, c);
    wr(`ADDR_ACC_MASK, m);
    wr(`ADDR_MODE, s ? 32'h0000_0008 : 32'h0000_0000);
    repeat (16)
    begin
      w = rnd();
      x = s ? seed[3] : 1'b1;
      // Half the identifiers are built to match so both outcomes occur
      if (rnd() & 32'h0000_0080)
        w = (c & ~m) | (w & m);
      fid(x, x ? w[31:3] : {18'h0_0000, w[31:21]}, s, c, m);
    end
  endtask : frand

  task automatic meas(output int per, output int hi);
    int t;
    logic p;
    t = 0;
    per = 0;
    hi = 0;
    do
    begin
      p = msig;
      @(posedge pclk);
      t++;
    end
    while (!(p === 1'b0 && msig === 1'b1) && t < 3000);
    do
    begin
      if (msig === 1'b1)
        hi++;
      p = msig;
      @(posedge pclk);
      per++;
    end
    while (!(p === 1'b0 && msig === 1'b1) && per < 3000);
    if (t >= 3000 || per >= 3000)
      n_fail++;
  endtask : meas

  task automatic check_rst();
    chk("cfg", config_state, 32'h0000_0001);
    rdc(`ADDR_MODE, 32'hffff_ffff, 32'h0000_0001);
    rdc(`ADDR_STATUS, 32'h0000_0041, 32'h0000_0001);
    rdc(`ADDR_IRQ_ENABLE, 32'hffff_ffff, 32'h0000_0000);
    rdc(`ADDR_WARN_LIMIT, 32'hffff_ffff, 32'h0000_0060);
    rdc(`ADDR_OUTPUT_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rdc(`ADDR_CLOCK_DIV, 32'hffff_ffff, 32'h0000_0008);
    rdc(`ADDR_ACC_CODE, 32'hffff_ffff, 32'h0000_0000);
    rdc(`ADDR_ACC_MASK, 32'hffff_ffff, 32'h0000_0000);
    $display("test reset done");
  endtask : check_rst

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end

  initial
  begin
    int p, h, ns;
    logic [31:0] ev, en;
    logic last;
    {presetn, psel, penable, pwrite, id_valid, id_extended, run, msel} = 8'h00;
    {paddr, pwdata, id_value, irq_events, tx_err_count, rx_err_count} = 97'h0;
    tx_bit = 1'b1;
    bit_clocks = 16'h0020;
    seed = 32'h0001_2436;
    n_fail = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check_rst();
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk("unmapped err", e, 32'h0000_0001);
    chk("unmapped data", q, 32'h0000_0000);
    wr(`ADDR_MODE, 32'h0000_0008);
    fid(1'b1, 29'h0000_0000, 1'b1, 32'h0000_0000, 32'h0000_0000);
    fid(1'b1, 29'h0000_0005, 1'b1, 32'h0000_0000, 32'h0000_0000);
    frand(1'b1);
    frand(1'b0);
    $display("test filter done");
    ra = '{`ADDR_BIT_TIMING_ZERO, `ADDR_BIT_TIMING_ONE, `ADDR_WARN_LIMIT, `ADDR_OUTPUT_CTRL,
      `ADDR_ACC_CODE, `ADDR_ACC_MASK, `ADDR_IRQ_ENABLE, `ADDR_CLOCK_DIV};
    // Four-clock quantum, 5 + 2 segments: an 8 quantum bit, jump width 2
    rv = '{32'h0000_0041, 32'h0000_0014, 32'h0000_000a, 32'h0000_0001, rnd(), rnd(),
      rnd() & 32'h0000_00ff, 32'h0000_000b};
    wr(`ADDR_MODE, 32'h0000_0001);
    for (int i = 0; i < 8; i++)
      wr(ra[i], rv[i]);
    for (int i = 0; i < 8; i++)
      rdc(ra[i], 32'hffff_ffff, rv[i]);
    wr(`ADDR_MODE, 32'h0000_0000);
    @(posedge pclk);
    chk("cfg", config_state, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
      wr(ra[i], ~rv[i]);
    for (int i = 0; i < 8; i++)
      rdc(ra[i], 32'hffff_ffff, rv[i]);
    msel = 1'b0;
    meas(p, h);
    chk("bit period", p, bitlen(rv[0], rv[1], 1'b0));
    chk("bit clock high", h, bitlen(rv[0], rv[1], 1'b1));
    wr(`ADDR_MODE, 32'h0000_0001);
    @(posedge pclk);
    chk("cfg", config_state, 32'h0000_0001);
    for (int i = 0; i < 8; i++)
      rdc(ra[i], 32'hffff_ffff, rv[i]);
    $display("test config done");
    wr(`ADDR_MODE, 32'h0000_0000);
    run <= 1'b1;
    repeat (96) @(posedge pclk);
    ns = 0;
    repeat (320)
    begin
      @(posedge pclk);
      if (sample_pulse === 1'b1)
      begin
        ns++;
        chk("sampled", sampled_bit, node_bit);
      end
    end
    chk("samples", ns, 10);
    run <= 1'b0;
    wr(`ADDR_EVENT_STATUS, 32'h0000_00ff);
    tx_err_count <= 8'h0b;
    repeat (3) @(posedge pclk);
    rdc(`ADDR_STATUS, 32'h0000_0040, 32'h0000_0040);
    rdc(`ADDR_EVENT_STATUS, 32'h0000_0004, 32'h0000_0004);
    chk("warn irq", irq_pending[2], rv[6][2]);
    tx_err_count <= 8'h0a;
    repeat (3) @(posedge pclk);
    rdc(`ADDR_STATUS, 32'h0000_0040, 32'h0000_0000);
    rx_err_count <= 8'h0b;
    repeat (3) @(posedge pclk);
    rdc(`ADDR_STATUS, 32'h0000_0040, 32'h0000_0040);
    rx_err_count <= 8'h00;
    $display("test warning done");
    repeat (4)
    begin
      en = rnd() & 32'h0000_00ff;
      wr(`ADDR_IRQ_ENABLE, en);
      wr(`ADDR_EVENT_STATUS, 32'h0000_00ff);
      ev = rnd() & 32'h0000_00fb;
      @(posedge pclk);
      irq_events <= ev[7:0];
      @(posedge pclk);
      irq_events <= 8'h00;
      repeat (2) @(posedge pclk);
      chk("pending", irq_pending, ev & en);
      rdc(`ADDR_EVENT_STATUS, 32'h0000_00ff, ev);
    end
    $display("test interrupts done");
    wr(`ADDR_MODE, 32'h0000_0001);
    wr(`ADDR_OUTPUT_CTRL, 32'h0000_0000);
    wr(`ADDR_MODE, 32'h0000_0000);
    wr(`ADDR_OUTPUT_CTRL, 32'h0000_0001);
    rdc(`ADDR_OUTPUT_CTRL, 32'hffff_ffff, 32'h0000_0000);
    last = tx_bit;
    repeat (24)
    begin
      @(posedge pclk);
      chk("primary", tx_pin_primary, last);
      chk("secondary", tx_pin_secondary, {31'h0, !last});
      last = tx_bit;
      tx_bit <= seed[5];
      ev = rnd();
    end
    tx_bit <= 1'b1;
    msel = 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      wr(`ADDR_CLOCK_DIV, 32'h0000_0008 | n);
      meas(p, h);
      chk("div period", p, 2 * ((n > 6) ? 7 : n + 1));
      chk("div high", h, (n > 6) ? 7 : n + 1);
    end
    wr(`ADDR_CLOCK_DIV, 32'h0000_0002);
    // The pin may still toggle or drop at the write edge; let it settle first
    repeat (2) @(posedge pclk);
    chk("div off level", divided_clock_pin, 32'h0000_0000);
    ns = 0;
    last = divided_clock_pin;
    repeat (40)
    begin
      @(posedge pclk);
      if (divided_clock_pin !== last)
        ns++;
      last = divided_clock_pin;
    end
    chk("div off", ns, 0);
    $display("test outputs done");
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check_rst();
    summarize();
  end
endmodule : can_controller_config_tb
`default_nettype wire
